//--- verilog/eam_top.sv
// effective-address modifier with character extract and insert, APB slave
// assumes one 250 MHz clock and a held memory request acknowledged by mem_ack
`timescale 1ns/100ps
`default_nettype none
`include "eam_consts.svh"
module eam_top
  import eam_pkg::*;
(
  input wire logic core_clk, // processor clock
  input wire logic reset_n, // asynchronous reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic mem_req, // memory request, held until ack
  output logic mem_we, // memory write
  output logic [17:0] mem_addr, // memory word address
  output logic [35:0] mem_wdata, // memory write word
  input wire logic [35:0] mem_rdata, // memory read word
  input wire logic mem_ack // memory answer
);
  rf_if rf ();

  logic rst_meta_q, rst_n_q;
  state_t state_q, state_d;
  addr_t addr_q, addr_d, ea_q, ea_d, maddr_q, maddr_d;
  logic [1:0] tm_q, tm_d;
  logic [3:0] td_q, td_d, irtd_q, irtd_d;
  logic irp_q, irp_d, cont_q, cont_d, char_q, char_d;
  logic [2:0] cpos_q, cpos_d;
  word_t oper_q, oper_d, mwd_q, mwd_d, store_data_q;
  logic fault_q, fault_d, done_q, done_d, tz_q, tz_d, dir_q, dir_d;
  logic [23:0] instr_q;
  logic store_q, go_q, rdy_q;
  logic [3:0] hiwr_q, hird_q;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  reg_bank u_bank (
    .core_clk(core_clk),
    .rst_n(rst_n_q),
    .rf(rf.bank)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic rf_idx_t rf_sel(logic [3:0] td);
    if (td[`TD_XBIT]) begin
      rf_sel = {1'b0, td[2:0]};
    end else if (td == `TD_QU || td == `TD_QL) begin
      rf_sel = `RF_Q;
    end else if (td == `TD_IC) begin
      rf_sel = `RF_IC;
    end else begin
      rf_sel = `RF_A;
    end
  endfunction : rf_sel

  function automatic addr_t index_val(logic [3:0] td, word_t r);
    if (td[`TD_XBIT] || td == `TD_AL || td == `TD_QL || td == `TD_IC) begin
      index_val = r[`F_LOW];
    end else if (td == `TD_AU || td == `TD_QU) begin
      index_val = r[`F_ADDR];
    end else begin
      index_val = '0;
    end
  endfunction : index_val

  // six 6-bit characters, position 0 leftmost
  function automatic logic [5:0] char_shift(logic [2:0] p);
    char_shift = 6'(`CHAR_W * (`CPOS_LAST - p));
  endfunction : char_shift

  function automatic word_t char_pick(word_t w, logic [2:0] p);
    word_t s;
    s = w >> char_shift(p);
    char_pick = {30'h0, s[`F_CH5]};
  endfunction : char_pick

  function automatic word_t char_put(word_t w, logic [2:0] p, logic [5:0] c);
    word_t m;
    m = {30'h0, 6'h3F} << char_shift(p);
    char_put = (w & ~m) | ({30'h0, c} << char_shift(p));
  endfunction : char_put

  // ----------------------------------------------------------------
  // index source and address sums
  // ----------------------------------------------------------------
  logic [3:0] eff_td, eff_td_nx;
  addr_t sum, ra, ra_up, ra_dn;
  logic [11:0] rt, rt_up, rt_dn;
  logic direct;
  assign eff_td = (tm_q == `TM_R && irp_q) ? irtd_q : td_q;
  assign eff_td_nx = (tm_d == `TM_R && irp_d) ? irtd_d : td_d;
  // index word fetched while the address is loaded
  assign rf.eng_idx = rf_sel(eff_td_nx);
  assign sum = addr_q + index_val(eff_td, rf.eng_data);
  assign ra = mem_rdata[`F_ADDR];
  assign ra_up = ra + 18'h1;
  assign ra_dn = ra - 18'h1;
  assign rt = mem_rdata[`F_TALLY];
  assign rt_up = rt + 12'h1;
  assign rt_dn = rt - 12'h1;
  assign direct = eff_td == `TD_DU || eff_td == `TD_DL;

  // ----------------------------------------------------------------
  // modification sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    ea_d = ea_q;
    maddr_d = maddr_q;
    tm_d = tm_q;
    td_d = td_q;
    irp_d = irp_q;
    irtd_d = irtd_q;
    cont_d = cont_q;
    char_d = char_q;
    cpos_d = cpos_q;
    oper_d = oper_q;
    mwd_d = mwd_q;
    fault_d = fault_q;
    done_d = done_q;
    tz_d = tz_q;
    dir_d = dir_q;
    unique case (state_q)
      S_IDLE: begin
        if (go_q) begin
          addr_d = instr_q[`I_Y];
          tm_d = instr_q[`I_TM];
          td_d = instr_q[`I_TD];
          {irp_d, cont_d, char_d, fault_d, done_d, tz_d, dir_d} = '0;
          state_d = S_EVAL;
        end
      end
      S_EVAL: begin
        unique case (tm_q)
          `TM_R: begin
            if (direct) begin
              oper_d = (eff_td == `TD_DU) ? {addr_q, 18'h0} : {18'h0, addr_q};
              dir_d = 1'b1;
              state_d = S_DONE;
            end else begin
              // register add, saved designator if chained
              ea_d = sum;
              state_d = S_OPER;
            end
          end
          `TM_RI: begin
            addr_d = sum;
            maddr_d = sum;
            state_d = S_IND_RD;
          end
          `TM_IR: begin
            // remember the last designator of the chain
            irp_d = 1'b1;
            irtd_d = td_q;
            maddr_d = addr_q;
            state_d = S_IND_RD;
          end
          `TM_IT: begin
            maddr_d = addr_q;
            state_d = S_IND_RD;
          end
        endcase
      end
      S_IND_RD: begin
        if (mem_ack) begin
          cont_d = 1'b0;
          if (tm_q != `TM_IT) begin
            addr_d = ra;
            tm_d = mem_rdata[`F_TM];
            td_d = mem_rdata[`F_TD];
            state_d = S_EVAL;
          end else begin
            // indirect address is the operand address; DI and DIC use it less one
            ea_d = ra;
            state_d = S_IND_WB;
            case (td_q)
              `V_I: begin
                state_d = S_OPER;
              end
              `V_ID, `V_IDC: begin
                mwd_d = {ra_up, rt_dn, mem_rdata[`F_TAG]};
                tz_d = rt_dn == '0;
                cont_d = td_q == `V_IDC;
                addr_d = ra;
              end
              `V_DI, `V_DIC: begin
                mwd_d = {ra_dn, rt_up, mem_rdata[`F_TAG]};
                ea_d = ra_dn;
                cont_d = td_q == `V_DIC;
                addr_d = ra_dn;
              end
              `V_SC: begin
                // octal position in the low three bits
                cpos_d = mem_rdata[`F_CPOS];
                char_d = 1'b1;
                tz_d = rt_dn == '0;
                // step the word after the last position
                if (mem_rdata[`F_CPOS] == `CPOS_LAST) begin
                  mwd_d = {ra_up, rt_dn, 3'h0, `CPOS_FIRST};
                end else begin
                  mwd_d = {ra, rt_dn, 3'h0, 3'(mem_rdata[`F_CPOS] + 3'h1)};
                end
              end
              `V_CI: begin
                cpos_d = mem_rdata[`F_CPOS];
                char_d = 1'b1;
                state_d = S_OPER;
              end
              `V_AD: begin
                mwd_d = {18'(ra + {12'h0, mem_rdata[`F_TAG]}), rt_dn, mem_rdata[`F_TAG]};
                tz_d = rt_dn == '0;
              end
              default: begin
                fault_d = 1'b1;
                state_d = S_DONE;
              end
            endcase
            if (mem_rdata[`F_ZERO] != 3'h0 && (td_q == `V_SC || td_q == `V_CI)) begin
              fault_d = 1'b1;
              state_d = S_DONE;
            end
          end
        end
      end
      S_IND_WB: begin
        if (mem_ack) begin
          if (cont_q) begin
            // continue with the word's own tag
            td_d = mwd_q[`F_TD];
            tm_d = mwd_q[`F_TM];
            state_d = S_EVAL;
          end else begin
            state_d = S_OPER;
          end
        end
      end
      S_OPER: begin
        maddr_d = ea_q;
        mwd_d = store_data_q;
        state_d = (store_q && !char_q) ? S_OP_WR : S_OP_RD;
      end
      S_OP_RD: begin
        if (mem_ack) begin
          if (store_q) begin
            // merge character five into the chosen position
            mwd_d = char_put(mem_rdata, cpos_q, store_data_q[`F_CH5]);
            state_d = S_OP_WR;
          end else begin
            oper_d = char_q ? char_pick(mem_rdata, cpos_q) : mem_rdata;
            state_d = S_DONE;
          end
        end
      end
      S_OP_WR: begin
        if (mem_ack) begin
          state_d = S_DONE;
        end
      end
      S_DONE: begin
        done_d = 1'b1;
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
      {addr_q, ea_q, maddr_q} <= '0;
      {tm_q, td_q, irtd_q, cpos_q} <= '0;
      {irp_q, cont_q, char_q, fault_q, done_q, tz_q, dir_q} <= '0;
      {oper_q, mwd_q} <= '0;
    end else begin
      state_q <= state_d;
      {addr_q, ea_q, maddr_q} <= {addr_d, ea_d, maddr_d};
      {tm_q, td_q, irtd_q, cpos_q} <= {tm_d, td_d, irtd_d, cpos_d};
      {irp_q, cont_q, char_q, fault_q, done_q, tz_q, dir_q} <= {irp_d, cont_d, char_d, fault_d, done_d, tz_d, dir_d};
      {oper_q, mwd_q} <= {oper_d, mwd_d};
    end
  end

  // memory port
  assign mem_req = state_q == S_IND_RD || state_q == S_IND_WB || state_q == S_OP_RD || state_q == S_OP_WR;
  assign mem_we = state_q == S_IND_WB || state_q == S_OP_WR;
  assign mem_addr = maddr_q;
  assign mem_wdata = mwd_q;

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  logic busy, hit_rf, hit_any, wr_acc, first_acc;
  logic [7:0] off;
  logic [31:0] rd_mux;
  assign busy = state_q != S_IDLE;
  assign off = paddr;
  assign hit_rf = off[7:6] == `RF_PAGE && off[5:2] < 4'(`RF_DEPTH) && off[1:0] == 2'h0;
  assign hit_any = hit_rf || off == `A_CTRL || off == `A_STAT || off == `A_INSTR || off == `A_EA ||
    off == `A_OPLO || off == `A_OPHI || off == `A_STLO || off == `A_STHI || off == `A_HIWR || off == `A_HIRD;
  assign pready = psel && penable && rdy_q;
  assign pslverr = pready && !hit_any;
  assign wr_acc = pready && pwrite && hit_any;
  assign first_acc = psel && penable && !rdy_q;
  assign prdata = prdata_q;
  assign rf.bus_idx = off[5:2];
  assign rf.wr_en = wr_acc && hit_rf;
  assign rf.wr_idx = off[5:2];
  assign rf.wr_data = {hiwr_q, pwdata};
  assign rd_mux = hit_rf ? rf.bus_data[`F_LO] :
    off == `A_STAT ? {27'h0, dir_q, tz_q, fault_q, done_q, busy} :
    off == `A_INSTR ? {8'h0, instr_q} :
    off == `A_EA ? {14'h0, ea_q} :
    off == `A_OPLO ? oper_q[`F_LO] :
    off == `A_OPHI ? {28'h0, oper_q[`F_HI]} :
    off == `A_STLO ? store_data_q[`F_LO] :
    off == `A_STHI ? {28'h0, store_data_q[`F_HI]} :
    off == `A_HIWR ? {28'h0, hiwr_q} :
    off == `A_HIRD ? {28'h0, hird_q} :
    off == `A_CTRL ? {30'h0, store_q, 1'b0} : 32'h0;

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      {rdy_q, go_q, store_q} <= '0;
      {instr_q, store_data_q, hiwr_q, hird_q, prdata_q} <= '0;
    end else begin
      rdy_q <= first_acc;
      go_q <= wr_acc && off == `A_CTRL && pwdata[`CTRL_GO] && !busy;
      if (first_acc) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux;
      end
      if (first_acc && !pwrite && hit_rf) begin
        hird_q <= rf.bus_data[`F_HI];
      end
      if (wr_acc && off == `A_CTRL && !busy) begin
        store_q <= pwdata[`CTRL_STORE];
      end
      if (wr_acc && off == `A_INSTR && !busy) begin
        instr_q <= pwdata[23:0];
      end
      if (wr_acc && off == `A_STLO) begin
        store_data_q[`F_LO] <= pwdata;
      end
      if (wr_acc && off == `A_STHI) begin
        store_data_q[`F_HI] <= pwdata[3:0];
      end
      if (wr_acc && off == `A_HIWR) begin
        hiwr_q <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_q);

  direct_lower_a: assert property ((state_q == S_EVAL && tm_q == `TM_R && eff_td == `TD_DL) |=>
    (state_q == S_DONE && oper_q == {18'h0, $past(addr_q)})) else $error("direct operand wrong");
  reg_add_a: assert property ((state_q == S_EVAL && tm_q == `TM_R && !direct) |=>
    (state_q == S_OPER && ea_q == $past(sum))) else $error("indexed address wrong");
  up_count_a: assert property ((state_q == S_IND_RD && mem_ack && tm_q == `TM_IT && td_q == `V_ID) |=>
    (mwd_q[`F_ADDR] == 18'($past(ra) + 18'h1) && mwd_q[`F_TALLY] == 12'($past(rt) - 12'h1)))
    else $error("address up tally down wrong");
  plain_ind_a: assert property ((state_q == S_IND_RD && mem_ack && tm_q == `TM_IT && td_q == `V_I) |=>
    (state_q == S_OPER) ##1 (state_q != S_IND_WB)) else $error("plain indirect word rewritten");
  fault_var_a: assert property ((state_q == S_IND_RD && mem_ack && tm_q == `TM_IT && td_q == `V_F) |=>
    (fault_q && state_q == S_DONE) ##1 (done_q && state_q == S_IDLE)) else $error("fault variant missed");
  char_wrap_a: assert property ((state_q == S_IND_RD && mem_ack && tm_q == `TM_IT && td_q == `V_SC &&
    mem_rdata[`F_CPOS] == `CPOS_LAST && mem_rdata[`F_ZERO] == 3'h0) |=>
    (mwd_q[`F_CPOS] == `CPOS_FIRST && mwd_q[`F_ADDR] == 18'($past(ra) + 18'h1))) else $error("position wrap wrong");
  char_read_a: assert property ((state_q == S_OP_RD && mem_ack && char_q && !store_q) |=>
    (oper_q[35:6] == 30'h0 && state_q == S_DONE)) else $error("character not right-justified");
  fixed_char_a: assert property ((state_q == S_IND_RD && mem_ack && tm_q == `TM_IT && td_q == `V_CI &&
    mem_rdata[`F_ZERO] == 3'h0) |=> (state_q == S_OPER && char_q) ##1 (state_q != S_IND_WB))
    else $error("fixed character word touched");
endmodule : eam_top
`default_nettype wire

//--- verilog/eam_consts.svh
// named constants of the effective-address modifier: codes, fields, offsets
// assumes 36-bit words with bit 35 as the leftmost (bit 0 of the word format)
`ifndef EAM_CONSTS_SVH
`define EAM_CONSTS_SVH

// ----------------------------------------------------------------
// modification type and designator codes
// ----------------------------------------------------------------
// codes are free choices
`define TM_R 2'h0
`define TM_RI 2'h1
`define TM_IT 2'h2
`define TM_IR 2'h3
`define TD_NONE 4'h0
`define TD_AU 4'h1
`define TD_QU 4'h2
`define TD_DU 4'h3
`define TD_IC 4'h4
`define TD_AL 4'h5
`define TD_QL 4'h6
`define TD_DL 4'h7
`define TD_XBIT 3
`define V_I 4'h0
`define V_ID 4'h1
`define V_DI 4'h2
`define V_SC 4'h3
`define V_CI 4'h4
`define V_AD 4'h5
`define V_F 4'h6
`define V_IDC 4'h7
`define V_DIC 4'h8

// ----------------------------------------------------------------
// word fields
// ----------------------------------------------------------------
`define F_ADDR 35:18
`define F_LOW 17:0
`define F_TALLY 17:6
`define F_TAG 5:0
`define F_TM 5:4
`define F_TD 3:0
`define F_ZERO 5:3
`define F_CPOS 2:0
`define F_CH5 5:0
`define F_HI 35:32
`define F_LO 31:0
`define CHAR_W 6
`define CPOS_LAST 3'h5
`define CPOS_FIRST 3'h0
`define I_Y 17:0
`define I_TM 23:22
`define I_TD 21:18

// ----------------------------------------------------------------
// register bank and bus map
// ----------------------------------------------------------------
`define RF_DEPTH 11
`define RF_A 4'h8
`define RF_Q 4'h9
`define RF_IC 4'hA
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_INSTR 8'h08
`define A_EA 8'h0C
`define A_OPLO 8'h10
`define A_OPHI 8'h14
`define A_STLO 8'h18
`define A_STHI 8'h1C
`define A_HIWR 8'h20
`define A_HIRD 8'h24
`define RF_PAGE 2'h1
`define CTRL_GO 0
`define CTRL_STORE 1

`endif

//--- verilog/eam_pkg.sv
// types shared by the effective-address modifier and its register bank
// assumes nothing beyond the constants header
package eam_pkg;
  typedef logic [35:0] word_t;
  typedef logic [17:0] addr_t;
  typedef logic [3:0] rf_idx_t;
  typedef enum logic [2:0] {S_IDLE, S_EVAL, S_IND_RD, S_IND_WB, S_OPER, S_OP_RD, S_OP_WR, S_DONE} state_t;
endpackage : eam_pkg

//--- verilog/rf_if.sv
// carrier between the modifier and its register bank
// assumes one clock; read data returns one edge after the index
`timescale 1ns/100ps
`default_nettype none
interface rf_if;
  import eam_pkg::*;
  logic wr_en;
  rf_idx_t wr_idx;
  word_t wr_data;
  rf_idx_t eng_idx;
  word_t eng_data;
  rf_idx_t bus_idx;
  word_t bus_data;
  modport ctl (output wr_en, wr_idx, wr_data, eng_idx, bus_idx, input eng_data, bus_data);
  modport bank (input wr_en, wr_idx, wr_data, eng_idx, bus_idx, output eng_data, bus_data);
endinterface : rf_if
`default_nettype wire

//--- verilog/reg_bank.sv
// index, accumulator, quotient and counter words with two registered reads
// assumes synchronous reset copy from the top module
`timescale 1ns/100ps
`default_nettype none
`include "eam_consts.svh"
module reg_bank
  import eam_pkg::*;
(
  input wire logic core_clk, // processor clock
  input wire logic rst_n, // synchronised reset, low active
  rf_if.bank rf // engine and bus ports
);
  word_t mem_q [`RF_DEPTH];

  // ----------------------------------------------------------------
  // storage and registered reads
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `RF_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rf.eng_data <= '0;
      rf.bus_data <= '0;
    end else begin
      if (rf.wr_en) begin
        mem_q[rf.wr_idx] <= rf.wr_data;
      end
      rf.eng_data <= mem_q[rf.eng_idx];
      rf.bus_data <= mem_q[rf.bus_idx];
    end
  end
endmodule : reg_bank
`default_nettype wire

//--- bench/mem_model.sv
// memory partner of the modifier: word store that answers after a set lag
// assumes mem_req is held until mem_ack, same clock
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input wire logic core_clk, // clock
  input wire logic mem_req, // request level
  input wire logic mem_we, // write request
  input wire logic [17:0] mem_addr, // word address
  input wire logic [35:0] mem_wdata, // write word
  input wire logic [3:0] lag, // wait cycles before answer
  output logic [35:0] mem_rdata, // read word, scrambled off the ack
  output logic mem_ack // one-cycle answer
);
  logic [35:0] words [0:255];
  logic [3:0] wait_q = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 36'h0;
  // answer after lag cycles; read data means nothing outside the ack cycle
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == lag) begin
        wait_q <= 4'h0;
        mem_ack <= 1'b1;
        mem_rdata <= words[mem_addr[7:0]];
        if (mem_we) begin
          words[mem_addr[7:0]] <= mem_wdata;
        end
      end
    end
  end
endmodule : mem_model
`default_nettype wire

//--- bench/effective_address_modifier_bench.sv
// self-checking bench of the effective-address modifier
// assumes the memory partner model and the design's APB map
`timescale 1ns/100ps
`default_nettype none
`include "eam_consts.svh"
module effective_address_modifier_bench;
  logic core_clk, reset_n, psel, penable, pwrite, mem_req, mem_we, mem_ack, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [17:0] mem_addr;
  logic [35:0] mem_wdata, mem_rdata;
  logic [3:0] lag;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  eam_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mem_model mem_u (.core_clk(core_clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lag(lag), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [35:0] act, input logic [35:0] exp);
    tests_run++;
    if (act !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk
  // one APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // load an instruction, start, poll busy low
  task automatic run_op(input logic [31:0] instr, input logic [31:0] ctrl);
    apb(1'b1, `A_INSTR, instr);
    apb(1'b1, `A_CTRL, ctrl);
    do begin
      apb(1'b0, `A_STAT, 32'h0);
    end while (q[0] !== 1'b0);
  endtask : run_op
  // tally variant on indirect word at 0x10: check address and word left behind
  task automatic it_case(input logic [3:0] v, input logic [35:0] w, input logic [17:0] ea, input logic [35:0] wn);
    mem_u.words[8'h10] = w;
    run_op({8'h00, `TM_IT, v, 18'h00010}, 32'h1);
    apb(1'b0, `A_EA, 32'h0);
    chk({18'h0, q[17:0]}, {18'h0, ea});
    chk(mem_u.words[8'h10], wn);
  endtask : it_case
  task automatic r_case(input logic [1:0] tm, input logic [3:0] td, input logic [17:0] y, input logic [17:0] ea);
    run_op({8'h00, tm, td, y}, 32'h1);
    apb(1'b0, `A_EA, 32'h0);
    chk({18'h0, q[17:0]}, {18'h0, ea});
  endtask : r_case
  // main sequence
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lag = 4'h0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    it_case(`V_I, {18'h00020, 12'h003, 6'h00}, 18'h00020, {18'h00020, 12'h003, 6'h00});
    it_case(`V_ID, {18'h00020, 12'h003, 6'h00}, 18'h00020, {18'h00021, 12'h002, 6'h00});
    it_case(`V_DI, {18'h00020, 12'h003, 6'h00}, 18'h0001F, {18'h0001F, 12'h004, 6'h00});
    lag <= 4'h3;
    it_case(`V_AD, {18'h3FFF0, 12'h003, 6'h15}, 18'h3FFF0, {18'h00005, 12'h002, 6'h15});
    mem_u.words[8'h30] = 36'h1_2345_6789;
    it_case(`V_SC, {18'h00030, 12'h002, 6'h02}, 18'h00030, {18'h00030, 12'h001, 6'h03});
    it_case(`V_SC, {18'h00030, 12'h001, 6'h05}, 18'h00030, {18'h00031, 12'h000, 6'h00});
    apb(1'b0, `A_STAT, 32'h0);
    chk({35'h0, q[3]}, 36'h1);
    apb(1'b0, `A_OPLO, 32'h0);
    chk({4'h0, q}, 36'h0_0000_0009);
    it_case(`V_CI, {18'h00030, 12'h001, 6'h03}, 18'h00030, {18'h00030, 12'h001, 6'h03});
    apb(1'b0, `A_OPLO, 32'h0);
    chk({4'h0, q}, 36'h0_0000_0016);
    apb(1'b1, `A_STLO, 32'h0000_003F);
    apb(1'b1, `A_STHI, 32'h0);
    run_op({8'h00, `TM_IT, `V_CI, 18'h00010}, 32'h3);
    chk(mem_u.words[8'h30], 36'h1_2347_F789);
    run_op({8'h00, `TM_IT, `V_F, 18'h00010}, 32'h1);
    chk({35'h0, q[2]}, 36'h1);
    apb(1'b1, `A_HIWR, 32'h0);
    apb(1'b1, 8'h4C, 32'h0000_0100);
    r_case(`TM_R, 4'hB, 18'h3FFFF, 18'h000FF);
    it_case(`V_IDC, {18'h00040, 12'h002, 6'h0B}, 18'h00140, {18'h00041, 12'h001, 6'h0B});
    it_case(`V_DIC, {18'h00040, 12'h002, 6'h0B}, 18'h0013F, {18'h0003F, 12'h003, 6'h0B});
    mem_u.words[8'h10] = 36'h0_0140_0000;
    r_case(`TM_RI, 4'hB, 18'h3FF10, 18'h00050);
    r_case(`TM_IR, 4'hB, 18'h00010, 18'h00150);
    apb(1'b1, `A_HIWR, 32'h5);
    apb(1'b1, 8'h60, 32'h1234_5678);
    r_case(`TM_R, `TD_AU, 18'h00010, 18'h1449D);
    run_op({8'h00, `TM_R, `TD_DL, 18'h01234}, 32'h1);
    chk({35'h0, q[4]}, 36'h1);
    apb(1'b0, `A_OPLO, 32'h0);
    chk({4'h0, q}, 36'h0_0000_1234);
    run_op({8'h00, `TM_R, `TD_DU, 18'h01234}, 32'h1);
    apb(1'b0, `A_OPLO, 32'h0);
    chk({4'h0, q}, 36'h0_48D0_0000);
    apb(1'b0, 8'hFC, 32'h0);
    chk({35'h0, e}, 36'h1);
    chk({4'h0, q}, 36'h0);
    complete_run();
  end
endmodule : effective_address_modifier_bench
`default_nettype wire
